// file: hdl/eprom_prog_ctrl.sv
// host controller that reads, programs and verifies a uv eprom
`timescale 1ns/1ns
`default_nettype none
module eprom_prog_ctrl #(
    parameter int PULSE_CYC = eprom_prog_pkg::PULSE_NOM_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic REQ_VALID,
    input wire eprom_prog_pkg::req_type REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output eprom_prog_pkg::rsp_type RSP,
    output logic [eprom_prog_pkg::ADDR_W-1:0] ADDR,
    input wire logic [eprom_prog_pkg::DATA_W-1:0] DATA_I,
    output logic [eprom_prog_pkg::DATA_W-1:0] DATA_O,
    output logic DATA_OE,
    output logic CHIP_SELECT_PROGRAM_STROBE_N,
    output logic OUTPUT_GATE_N,
    output logic VPP_HIGH
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_VPP = 3'b001,
        ST_SETUP = 3'b010,
        ST_PULSE = 3'b011,
        ST_HOLD = 3'b100,
        ST_ACCESS = 3'b101,
        ST_FLOAT = 3'b110
    } state_type;

    state_type state_r, state_nxt;
    logic [eprom_prog_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    eprom_prog_pkg::req_type req_r, req_nxt;
    logic [eprom_prog_pkg::DATA_W-1:0] din_meta_r, din_sync_r;
    logic ready_r, ready_nxt, rsp_valid_r, rsp_valid_nxt;
    eprom_prog_pkg::rsp_type rsp_r, rsp_nxt;
    logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, vpp_r, vpp_nxt;
    logic doe_r, doe_nxt;

    localparam logic [eprom_prog_pkg::CNT_W-1:0] PULSE_LAST =
        eprom_prog_pkg::CNT_W'(PULSE_CYC - 1);
    // data pins turn on one cycle into setup, so count one cycle more
    localparam logic [eprom_prog_pkg::CNT_W-1:0] SETUP_LAST =
        eprom_prog_pkg::CNT_W'(eprom_prog_pkg::SETUP_CYC);
    localparam logic [eprom_prog_pkg::CNT_W-1:0] HOLD_LAST =
        eprom_prog_pkg::CNT_W'(eprom_prog_pkg::HOLD_CYC - 1);
    // the supply moves one cycle after the strobe drops
    localparam logic [eprom_prog_pkg::CNT_W-1:0] VPP_LAST =
        eprom_prog_pkg::CNT_W'(eprom_prog_pkg::VPP_SETTLE_CYC);
    // two sync stages plus access delay before sampling
    localparam logic [eprom_prog_pkg::CNT_W-1:0] ACC_LAST =
        eprom_prog_pkg::CNT_W'(eprom_prog_pkg::OE_ACC_CYC + 1);
    localparam logic [eprom_prog_pkg::CNT_W-1:0] FLOAT_LAST =
        eprom_prog_pkg::CNT_W'(eprom_prog_pkg::FLOAT_CYC - 1);

    // decoded conditions
    wire take = REQ_VALID && ready_r;
    wire take_prog = take && (REQ.cmd == eprom_prog_pkg::CMD_PROGRAM);
    wire take_ver = take && (REQ.cmd == eprom_prog_pkg::CMD_VERIFY);
    wire want_vpp = take_prog || take_ver;
    wire cnt_done_setup = (cnt_r == SETUP_LAST);
    wire cnt_done_pulse = (cnt_r == PULSE_LAST);
    wire cnt_done_hold = (cnt_r == HOLD_LAST);
    wire cnt_done_vpp = (cnt_r == VPP_LAST);
    wire cnt_done_acc = (cnt_r == ACC_LAST);
    wire cnt_done_float = (cnt_r == FLOAT_LAST);
    wire is_prog = (req_r.cmd == eprom_prog_pkg::CMD_PROGRAM);
    wire hv_r = is_prog || (req_r.cmd == eprom_prog_pkg::CMD_VERIFY);
    wire [eprom_prog_pkg::CNT_W-1:0] cnt_inc = cnt_r + 1'b1;
    // a programmed byte may only have cleared bits of an erased cell
    wire verify_bad = (din_sync_r != req_r.data);

    // data pins come from outside the clock domain
    always_ff @(posedge CLK) begin
        din_meta_r <= DATA_I;
        din_sync_r <= din_meta_r;
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_inc;
        req_nxt = req_r;
        ready_nxt = ready_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        vpp_nxt = vpp_r;
        doe_nxt = doe_r;
        unique case (state_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                // standby at read level; with the supply high a steady
                // high strobe would program, so it is held low instead
                ce_n_nxt = !vpp_r;
                oe_n_nxt = 1'b1;
                if (take) begin
                    req_nxt = REQ;
                    ready_nxt = 1'b0;
                    if (want_vpp != vpp_r) begin
                        // drop the strobe first, the supply moves next
                        ce_n_nxt = 1'b0;
                        state_nxt = ST_VPP;
                    end else begin
                        state_nxt = ST_SETUP;
                    end
                end
            end
            ST_VPP: begin
                // strobe low, so a moving supply is never a pulse
                ce_n_nxt = 1'b0;
                vpp_nxt = hv_r;
                if (cnt_done_vpp) begin
                    cnt_nxt = '0;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (is_prog) begin
                    // gate high, data driven, strobe low: inhibited
                    oe_n_nxt = 1'b1;
                    ce_n_nxt = 1'b0;
                    doe_nxt = 1'b1;
                end else begin
                    ce_n_nxt = 1'b0;
                    doe_nxt = 1'b0;
                end
                if (cnt_done_setup) begin
                    cnt_nxt = '0;
                    if (is_prog) begin
                        ce_n_nxt = 1'b1;
                        state_nxt = ST_PULSE;
                    end else begin
                        oe_n_nxt = 1'b0;
                        state_nxt = ST_ACCESS;
                    end
                end
            end
            ST_PULSE: begin
                // fixed count keeps the pulse inside its window
                if (cnt_done_pulse) begin
                    cnt_nxt = '0;
                    ce_n_nxt = 1'b0;
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // address, data and gate held past the falling edge
                if (cnt_done_hold) begin
                    cnt_nxt = '0;
                    doe_nxt = 1'b0;
                    // supply still high: keep the inhibit level
                    ce_n_nxt = 1'b0;
                    rsp_valid_nxt = 1'b1;
                    rsp_nxt = '{data: req_r.data, mismatch: 1'b0};
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_ACCESS: begin
                if (cnt_done_acc) begin
                    cnt_nxt = '0;
                    oe_n_nxt = 1'b1;
                    ce_n_nxt = !vpp_r;
                    rsp_nxt.data = din_sync_r;
                    rsp_nxt.mismatch = (req_r.cmd ==
                        eprom_prog_pkg::CMD_VERIFY) && verify_bad;
                    state_nxt = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                // let the device float before the pins are reused
                if (cnt_done_float) begin
                    rsp_valid_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // state registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            req_r <= '0;
            ready_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            vpp_r <= 1'b0;
            doe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            req_r <= req_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            vpp_r <= vpp_nxt;
            doe_r <= doe_nxt;
        end
    end

    // address and data come from the latched request, stable all along
    logic [eprom_prog_pkg::ADDR_W-1:0] addr_r;
    logic [eprom_prog_pkg::DATA_W-1:0] dout_r;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            addr_r <= '0;
            dout_r <= '0;
        end else if (take) begin
            addr_r <= REQ.addr;
            dout_r <= REQ.data;
        end
    end

    assign REQ_READY = ready_r;
    assign RSP_VALID = rsp_valid_r;
    assign RSP = rsp_r;
    assign ADDR = addr_r;
    assign DATA_O = dout_r;
    assign DATA_OE = doe_r;
    // the only per-part pin; the rest may be shared across parts
    assign CHIP_SELECT_PROGRAM_STROBE_N = ce_n_r;
    assign OUTPUT_GATE_N = oe_n_r;
    assign VPP_HIGH = vpp_r;
endmodule
`default_nettype wire

// file: hdl/eprom_prog_pkg.sv
// constants and carrier types for the uv eprom read/program controller
package eprom_prog_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 100;
    // program pulse width, nominal, min and max
    localparam int PULSE_NOM_US = 50000;
    localparam int PULSE_MIN_US = 45000;
    localparam int PULSE_MAX_US = 55000;
    localparam int PULSE_NOM_CYC = PULSE_NOM_US * 1000 / CLK_NS;
    // setup and hold times around the pulse
    localparam int SETUP_US = 2;
    localparam int HOLD_US = 2;
    localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
    // output gate access delay and output float delay
    localparam int OE_ACC_NS = 120;
    localparam int OE_ACC_CYC = (OE_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_NS = 120;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    // supply settling time after switching the programming level
    localparam int VPP_SETTLE_US = 2;
    localparam int VPP_SETTLE_CYC = (VPP_SETTLE_US * 1000 + CLK_NS - 1)
        / CLK_NS;
    localparam int CNT_W = 20;

    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_PROGRAM = 2'b01,
        CMD_VERIFY = 2'b10
    } cmd_type;

    typedef struct packed {
        cmd_type cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic mismatch;
    } rsp_type;
endpackage

// file: bench/eprom_prog_ctrl_sva.sv
// port assertions for the eprom read/program controller
`timescale 1ns/1ns
`default_nettype none
module eprom_prog_ctrl_sva #(
    parameter int PULSE_CYC = 50
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic REQ_VALID,
    input wire eprom_prog_pkg::req_type REQ,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic [eprom_prog_pkg::ADDR_W-1:0] ADDR,
    input wire logic [eprom_prog_pkg::DATA_W-1:0] DATA_O,
    input wire logic DATA_OE,
    input wire logic CHIP_SELECT_PROGRAM_STROBE_N,
    input wire logic OUTPUT_GATE_N,
    input wire logic VPP_HIGH
);
    logic [31:0] len_r;
    logic [3:0] cnt_r;
    eprom_prog_pkg::cmd_type cmd_r;
    // pulse is strobe high at programming level with the gate off
    wire cs = CHIP_SELECT_PROGRAM_STROBE_N;
    wire pulse = cs && VPP_HIGH && OUTPUT_GATE_N;
    wire take = REQ_VALID && REQ_READY;
    wire prog = cmd_r == eprom_prog_pkg::CMD_PROGRAM;
    wire hv = prog || cmd_r == eprom_prog_pkg::CMD_VERIFY;
    // pulse length, pulses since take and the command being served
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            len_r <= '0;
            cnt_r <= '0;
            cmd_r <= eprom_prog_pkg::CMD_READ;
        end else begin
            len_r <= pulse ? len_r + 32'h1 : 32'h0;
            if (take) begin
                cnt_r <= '0;
                cmd_r <= REQ.cmd;
            end else if (pulse && len_r == 32'h0) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    gate_off_a: assert property (DATA_OE |-> OUTPUT_GATE_N)
        else $error("gate low while driving data");
    vpp_rise_a: assert property ($rose(VPP_HIGH) |-> OUTPUT_GATE_N && hv)
        else $error("supply raised wrongly");
    vpp_read_a: assert property (!OUTPUT_GATE_N && !hv |-> !VPP_HIGH)
        else $error("read with supply high");
    verify_vpp_a: assert property (!OUTPUT_GATE_N && hv |-> VPP_HIGH)
        else $error("verify with supply low");
    pulse_len_a: assert property ($fell(cs) && DATA_OE |-> len_r == PULSE_CYC)
        else $error("pulse width wrong");
    pulse_max_a: assert property (len_r <= PULSE_CYC)
        else $error("pulse too long");
    pulse_setup_a: assert property ($rose(cs) && DATA_OE |->
        $past(DATA_OE, 20) && $past(ADDR, 20) == ADDR)
        else $error("setup before pulse too short");
    pulse_hold_a: assert property ($fell(cs) && DATA_OE |->
        (DATA_OE && $stable(ADDR) && $stable(DATA_O))[*8])
        else $error("hold after pulse broken");
    one_pulse_a: assert property (RSP_VALID && prog |-> cnt_r == 4'h1)
        else $error("not one pulse per program");
    no_pulse_a: assert property (RSP_VALID && !prog |-> cnt_r == 4'h0)
        else $error("pulse outside program");
    gate_sel_a: assert property (!OUTPUT_GATE_N |-> !cs)
        else $error("gate low while deselected");
    idle_inhibit_a: assert property (VPP_HIGH && REQ_READY |-> !cs)
        else $error("strobe high while idle at high supply");
    vpp_switch_a: assert property ($changed(VPP_HIGH) |-> !cs)
        else $error("supply switched with strobe high");
    cover property (RSP_VALID && prog);
    cover property (RSP_VALID && cmd_r == eprom_prog_pkg::CMD_VERIFY);
    cover property (RSP_VALID && !hv);
endmodule
bind eprom_prog_ctrl eprom_prog_ctrl_sva #(.PULSE_CYC(PULSE_CYC)) sva (
    .CLK(CLK),
    .NRST(NRST),
    .REQ_VALID(REQ_VALID),
    .REQ(REQ),
    .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID),
    .ADDR(ADDR),
    .DATA_O(DATA_O),
    .DATA_OE(DATA_OE),
    .CHIP_SELECT_PROGRAM_STROBE_N(CHIP_SELECT_PROGRAM_STROBE_N),
    .OUTPUT_GATE_N(OUTPUT_GATE_N),
    .VPP_HIGH(VPP_HIGH)
);
`default_nettype wire

// file: bench/eprom_model.sv
// behavioural uv eprom: erased ones, pulse programming, gated outputs
`timescale 1ns/1ns
`default_nettype none
module eprom_model (
    input wire logic sel_n,
    input wire logic gate_n,
    input wire logic vpp_high,
    input wire logic [10:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] q
);
    logic [7:0] mem [0:2047];
    logic armed;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        q = 8'h00;
        armed = 1'b0;
    end
    // low strobe with supply high is inhibit; only a pulse arms
    always @(posedge sel_n) armed = vpp_high && gate_n;
    // bits only clear, written when the pulse ends
    always @(negedge sel_n) begin
        if (armed && vpp_high && gate_n) mem[addr] = mem[addr] & din;
        armed = 1'b0;
    end
    // floating pins toggle so a stale byte never reads as good
    always @(sel_n, gate_n, addr) begin
        if (!sel_n && !gate_n) q = #120 mem[addr];
        else q = ~q;
    end
endmodule
`default_nettype wire

// file: bench/tb_uv_eprom_read_program_control.sv
// testbench: controller against the behavioural eprom
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    failures++; $display("unexpected at %0t: %h not %h", $time, a, b); \
    end end
module tb_uv_eprom_read_program_control;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic REQ_VALID = 1'b0;
    eprom_prog_pkg::req_type REQ = '0;
    eprom_prog_pkg::rsp_type RSP;
    logic REQ_READY, RSP_VALID, DATA_OE, CS_N, OE_N, VPP;
    logic [10:0] ADDR;
    logic [7:0] DATA_O, mq;
    wire [7:0] pins = DATA_OE ? DATA_O : mq;
    int failures = 0;
    int checked = 0;
    eprom_prog_ctrl #(.PULSE_CYC(50)) DUT (.CLK(CLK), .NRST(NRST),
        .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
        .RSP_VALID(RSP_VALID), .RSP(RSP), .ADDR(ADDR), .DATA_I(pins),
        .DATA_O(DATA_O), .DATA_OE(DATA_OE), .OUTPUT_GATE_N(OE_N),
        .CHIP_SELECT_PROGRAM_STROBE_N(CS_N), .VPP_HIGH(VPP));
    eprom_model rom (.sel_n(CS_N), .gate_n(OE_N), .vpp_high(VPP),
        .addr(ADDR), .din(pins), .q(mq));
    initial forever #50 CLK = ~CLK;
    // one request, held until taken, then wait for the answer
    task automatic req(input eprom_prog_pkg::cmd_type c,
            input logic [10:0] a, input logic [7:0] d);
        int n;
        @(negedge CLK);
        REQ = '{c, a, d};
        REQ_VALID = 1'b1;
        for (n = 0; n < 100 && REQ_READY !== 1'b1; n++) @(negedge CLK);
        @(negedge CLK);
        REQ_VALID = 1'b0;
        for (n = 0; n < 900 && RSP_VALID !== 1'b1; n++) @(negedge CLK);
        `CHK(RSP_VALID, 1'b1)
    endtask
    // erased part reads ones; an unknown command acts as a read
    task automatic t_erased;
        req(eprom_prog_pkg::CMD_READ, 11'h7ff, 8'h00);
        `CHK(RSP, {8'hff, 1'b0})
        req(eprom_prog_pkg::cmd_type'(2'b11), 11'h000, 8'h00);
        `CHK(RSP.data, 8'hff)
        `CHK(VPP, 1'b0)
    endtask
    // program, verify at high supply, then a read drops the supply
    task automatic t_prog;
        req(eprom_prog_pkg::CMD_PROGRAM, 11'h123, 8'ha5);
        `CHK(RSP.data, 8'ha5)
        req(eprom_prog_pkg::CMD_VERIFY, 11'h123, 8'ha5);
        `CHK(RSP, {8'ha5, 1'b0})
        `CHK(VPP, 1'b1)
        req(eprom_prog_pkg::CMD_READ, 11'h123, 8'h00);
        `CHK(RSP.data, 8'ha5)
        `CHK(VPP, 1'b0)
    endtask
    // a second pulse only clears bits; the neighbour stays erased
    task automatic t_clear;
        req(eprom_prog_pkg::CMD_PROGRAM, 11'h123, 8'h5a);
        req(eprom_prog_pkg::CMD_VERIFY, 11'h123, 8'h5a);
        `CHK(RSP, {8'h00, 1'b1})
        req(eprom_prog_pkg::CMD_VERIFY, 11'h124, 8'hff);
        `CHK(RSP, {8'hff, 1'b0})
    endtask
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge CLK);
        NRST = 1'b1;
        `CHK({CS_N, OE_N, VPP, DATA_OE}, 4'hc)
        t_erased;
        t_prog;
        t_clear;
        final_report;
    end
    // about 450 cycles expected; over six times that means a hang
    initial begin
        #(100 * 3000);
        failures++;
        final_report;
    end
endmodule
`default_nettype wire
